// ### inc/qec_pkg.sv
// Package for the quadrature encoder control block: register map, field layout, mode codes.
// Assumes a 32-bit classic Wishbone register bus with byte addresses.
package qec_pkg;

  localparam int unsigned QEC_DW = 32;
  localparam int unsigned QEC_AW = 8;
  localparam int unsigned QEC_CTRL_W = 16;

  // Register byte offsets
  localparam logic [QEC_AW-1:0] QEC_OFS_CTRL = 8'h00;
  localparam logic [QEC_AW-1:0] QEC_OFS_INIT = 8'h04;
  localparam logic [QEC_AW-1:0] QEC_OFS_GEC = 8'h08;
  localparam logic [QEC_AW-1:0] QEC_OFS_POS = 8'h0C;
  localparam logic [QEC_AW-1:0] QEC_OFS_STAT = 8'h10;

  // Control field positions
  localparam int unsigned QEC_BIT_EN = 15;
  localparam int unsigned QEC_BIT_RSV_HI = 14;
  localparam int unsigned QEC_BIT_SIDL = 13;
  localparam int unsigned QEC_PIM_HI = 12;
  localparam int unsigned QEC_PIM_LO = 10;
  localparam int unsigned QEC_BIT_IMB = 9;
  localparam int unsigned QEC_BIT_IMA = 8;
  localparam int unsigned QEC_BIT_RSV_LO = 7;

  // Reset value and writable bits of the control register
  localparam logic [QEC_CTRL_W-1:0] QEC_CTRL_RST = 16'h0000;
  localparam logic [QEC_CTRL_W-1:0] QEC_CTRL_WMASK = 16'hBF7F;

  // Status field positions
  localparam int unsigned QEC_STAT_RUN = 0;
  localparam int unsigned QEC_STAT_HOME = 1;
  localparam int unsigned QEC_STAT_ARM = 2;
  localparam int unsigned QEC_STAT_IDX = 3;

  // Position counter initialisation modes
  typedef enum logic [2:0] {
    QEC_PIM_NONE = 3'h0,
    QEC_PIM_IDX_RST = 3'h1,
    QEC_PIM_IDX_NEXT = 3'h2,
    QEC_PIM_HOME_IDX1 = 3'h3,
    QEC_PIM_HOME_IDX2 = 3'h4,
    QEC_PIM_GEC_RST = 3'h5,
    QEC_PIM_MODULO = 3'h6,
    QEC_PIM_RSVD = 3'h7
  } qec_pim_e;

endpackage : qec_pkg

// ### core/qec_sync.sv
// Pin synchroniser: three stages plus an output flip-flop per bit, output follows once stages two and three agree.
// Assumes inputs are asynchronous to sys_clk.
`timescale 1ns/1ps
`default_nettype none
module qec_sync #(
  parameter int unsigned W = 4
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic [W-1:0] pin_i,
  output logic [W-1:0] level_o
);
  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      logic s1_q;
      logic s2_q;
      logic s3_q;
      logic lvl_q;

      always_ff @(posedge sys_clk) begin
        if (srst) begin
          s1_q <= 1'b0;
          s2_q <= 1'b0;
          s3_q <= 1'b0;
          lvl_q <= 1'b0;
        end else begin
          s1_q <= pin_i[g];
          s2_q <= s1_q;
          s3_q <= s2_q;
          if (s2_q == s3_q) begin
            lvl_q <= s3_q;
          end
        end
      end

      assign level_o[g] = lvl_q;
    end
  endgenerate
endmodule // qec_sync
`default_nettype wire

// ### core/qec_quad.sv
// Quadrature step decoder and qualified index and home edge detector.
// Assumes synchronised phase, index and home levels on sys_clk.
`timescale 1ns/1ps
`default_nettype none
module qec_quad (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic phase_a,
  input wire logic phase_b,
  input wire logic index_lvl,
  input wire logic home_lvl,
  input wire logic match_a,
  input wire logic match_b,
  output logic step_up,
  output logic step_dn,
  output logic idx_ev,
  output logic home_ev
);
  logic a_q;
  logic b_q;
  logic match_q;
  logic home_q;
  logic moved;
  logic one_phase;
  logic idx_match;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      a_q <= 1'b0;
      b_q <= 1'b0;
      match_q <= 1'b0;
      home_q <= 1'b0;
    end else begin
      a_q <= phase_a;
      b_q <= phase_b;
      match_q <= idx_match;
      home_q <= home_lvl;
    end
  end

  assign moved = (a_q ^ phase_a) | (b_q ^ phase_b);
  assign one_phase = (a_q ^ phase_a) ^ (b_q ^ phase_b);
  assign step_up = moved & one_phase & ~(a_q ^ phase_b);
  assign step_dn = moved & one_phase & (a_q ^ phase_b);
  // Index counts only with both phases at the selected levels
  assign idx_match = index_lvl & (phase_a == match_a) & (phase_b == match_b);
  assign idx_ev = idx_match & ~match_q;
  assign home_ev = home_lvl & ~home_q;

  AST_IDX_PHASE: assert property (@(posedge sys_clk) disable iff (srst)
    idx_ev |-> (phase_a == match_a) && (phase_b == match_b) && index_lvl)
    else $error("index event with phases off the selected levels");
  AST_IDX_PHASE_B: assert property (@(posedge sys_clk) disable iff (srst)
    (index_lvl && !match_q && (phase_b != match_b)) |-> !idx_ev)
    else $error("index event despite phase B mismatch");
endmodule // qec_quad
`default_nettype wire

// ### core/qec_top.sv
// Quadrature encoder control: control register, position counter and Wishbone slave.
// Assumes a classic Wishbone master on sys_clk and encoder pins asynchronous to it.
//
// Notes on behaviour
// - Counter enable set lets the module counters run.
// - Counter enable clear stops counters; register accesses still complete.
// - Idle stop set halts the interface while the device is idle.
// - Idle stop clear keeps the interface running while idle.
// - Init mode is bits 12..10; code 111 is reserved and acts like none.
// - Mode 110 makes the position counter wrap between zero and compare value.
// - Mode 101 clears the counter whenever it equals the compare value.
// - Mode 100 loads the init value at the second index after home.
// - Mode 011 loads the init value at the first index after home.
// - Mode 010 loads the init value at the next index event.
// - Mode 001 clears the counter at every index event.
// - Phase A match bit, bit 8, picks the phase A level for an index.
// - Control bits 14 and 7 read zero and ignore writes.
//
// The register addresses and the Wishbone register port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module qec_top #(
  parameter int unsigned POS_W = 32
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [qec_pkg::QEC_AW-1:0] wb_adr_i,
  input wire logic [qec_pkg::QEC_DW-1:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [qec_pkg::QEC_DW-1:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic phase_a_input,
  input wire logic phase_b_input,
  input wire logic index_input,
  input wire logic home_input,
  input wire logic device_idle,
  output logic [POS_W-1:0] position_o,
  output logic running_o
);
  import qec_pkg::*;

  // Byte-lane mask from Wishbone select
  function automatic logic [QEC_DW-1:0] lane_mask(input logic [3:0] sel);
    lane_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
  endfunction

  // Apply a masked write onto an old register value
  function automatic logic [QEC_DW-1:0] merge(input logic [QEC_DW-1:0] old_v, input logic [QEC_DW-1:0] new_v,
                                              input logic [QEC_DW-1:0] m);
    merge = (old_v & ~m) | (new_v & m);
  endfunction

  logic ack_q;
  logic [QEC_DW-1:0] rdat_q;
  logic [QEC_DW-1:0] rdat_d;
  logic [QEC_CTRL_W-1:0] ctrl_q;
  logic [QEC_CTRL_W-1:0] ctrl_d;
  logic [POS_W-1:0] init_q;
  logic [POS_W-1:0] init_d;
  logic [POS_W-1:0] gec_q;
  logic [POS_W-1:0] gec_d;
  logic [POS_W-1:0] pos_q;
  logic [POS_W-1:0] pos_d;
  logic home_seen_q;
  logic home_seen_d;
  logic idx_cnt_q;
  logic idx_cnt_d;
  logic next_arm_q;
  logic next_arm_d;

  logic [3:0] pins_raw;
  logic [3:0] pins_lvl;
  logic step_up;
  logic step_dn;
  logic idx_ev;
  logic home_ev;

  wire logic bus_req = wb_cyc_i & wb_stb_i & ~ack_q;
  // Writes land at the edge where the master samples ack
  wire logic bus_wr = wb_cyc_i & wb_stb_i & wb_we_i & ack_q;
  wire logic [QEC_DW-1:0] wmask = lane_mask(wb_sel_i);
  wire logic hit_ctrl = (wb_adr_i == QEC_OFS_CTRL);
  wire logic hit_init = (wb_adr_i == QEC_OFS_INIT);
  wire logic hit_gec = (wb_adr_i == QEC_OFS_GEC);
  wire logic hit_pos = (wb_adr_i == QEC_OFS_POS);
  wire logic hit_stat = (wb_adr_i == QEC_OFS_STAT);
  wire logic wr_ctrl = bus_wr & hit_ctrl;

  wire logic ctl_en = ctrl_q[QEC_BIT_EN];
  wire logic ctl_sidl = ctrl_q[QEC_BIT_SIDL];
  wire logic ctl_ima = ctrl_q[QEC_BIT_IMA];
  wire logic ctl_imb = ctrl_q[QEC_BIT_IMB];
  wire qec_pim_e pim = qec_pim_e'(ctrl_q[QEC_PIM_HI:QEC_PIM_LO]);

  // Counters run only when enabled and not halted by idle
  wire logic run = ctl_en & ~(ctl_sidl & device_idle);

  // Pin synchronisation and decoding
  assign pins_raw = {home_input, index_input, phase_b_input, phase_a_input};

  qec_sync #(
    .W(4)
  ) u_sync (
    .sys_clk(sys_clk),
    .srst(srst),
    .pin_i(pins_raw),
    .level_o(pins_lvl)
  );

  qec_quad u_quad (
    .sys_clk(sys_clk),
    .srst(srst),
    .phase_a(pins_lvl[0]),
    .phase_b(pins_lvl[1]),
    .index_lvl(pins_lvl[2]),
    .home_lvl(pins_lvl[3]),
    .match_a(ctl_ima),
    .match_b(ctl_imb),
    .step_up(step_up),
    .step_dn(step_dn),
    .idx_ev(idx_ev),
    .home_ev(home_ev)
  );

  // Step value of the counter, with wrap in modulo mode
  wire logic is_mod = (pim == QEC_PIM_MODULO);
  wire logic at_gec = (pos_q == gec_q);
  wire logic at_zero = (pos_q == '0);
  wire logic [POS_W-1:0] pos_inc = (is_mod && at_gec) ? '0 : pos_q + 1'b1;
  wire logic [POS_W-1:0] pos_dec = (is_mod && at_zero) ? gec_q : pos_q - 1'b1;
  wire logic [POS_W-1:0] pos_step = step_up ? pos_inc : (step_dn ? pos_dec : pos_q);

  // Index, home and compare driven initialisation
  wire logic ev_idx_rst = idx_ev & (pim == QEC_PIM_IDX_RST);
  wire logic ev_gec_rst = (pim == QEC_PIM_GEC_RST) & at_gec;
  wire logic ev_next = idx_ev & (pim == QEC_PIM_IDX_NEXT) & next_arm_q;
  wire logic ev_home1 = idx_ev & (pim == QEC_PIM_HOME_IDX1) & home_seen_q;
  wire logic ev_home2 = idx_ev & (pim == QEC_PIM_HOME_IDX2) & home_seen_q & idx_cnt_q;
  wire logic ev_load = ev_next | ev_home1 | ev_home2;
  wire logic home_first = idx_ev & (pim == QEC_PIM_HOME_IDX2) & home_seen_q & ~idx_cnt_q;
  wire logic [QEC_CTRL_W-1:0] ctrl_wr_val = wb_dat_i[QEC_CTRL_W-1:0];
  wire logic arm_on_write = wr_ctrl & wb_sel_i[1] & (ctrl_wr_val[QEC_PIM_HI:QEC_PIM_LO] == QEC_PIM_IDX_NEXT);

  always_comb begin
    pos_d = pos_q;
    if (run) begin
      if (ev_idx_rst || ev_gec_rst) begin
        pos_d = '0;
      end else if (ev_load) begin
        pos_d = init_q;
      end else begin
        pos_d = pos_step;
      end
    end
  end

  always_comb begin
    home_seen_d = home_seen_q;
    idx_cnt_d = idx_cnt_q;
    if (run) begin
      if (ev_home1 || ev_home2) begin
        home_seen_d = 1'b0;
        idx_cnt_d = 1'b0;
      end else if (home_first) begin
        idx_cnt_d = 1'b1;
      end
      // A home edge in the same cycle as a load still arms
      if (home_ev) begin
        home_seen_d = 1'b1;
        idx_cnt_d = 1'b0;
      end
    end
  end

  always_comb begin
    next_arm_d = next_arm_q;
    if (run && ev_next) begin
      next_arm_d = 1'b0;
    end
    if (arm_on_write) begin
      next_arm_d = 1'b1;
    end
  end

  // Register writes
  wire logic [QEC_DW-1:0] ctrl_ext = {{(QEC_DW-QEC_CTRL_W){1'b0}}, ctrl_q};
  wire logic [QEC_DW-1:0] ctrl_m = merge(ctrl_ext, wb_dat_i, wmask);
  assign ctrl_d = wr_ctrl ? (ctrl_m[QEC_CTRL_W-1:0] & QEC_CTRL_WMASK) : ctrl_q;
  assign init_d = (bus_wr && hit_init) ? POS_W'(merge(QEC_DW'(init_q), wb_dat_i, wmask)) : init_q;
  assign gec_d = (bus_wr && hit_gec) ? POS_W'(merge(QEC_DW'(gec_q), wb_dat_i, wmask)) : gec_q;

  // Status word
  logic [QEC_DW-1:0] stat_w;
  always_comb begin
    stat_w = '0;
    stat_w[QEC_STAT_RUN] = run;
    stat_w[QEC_STAT_HOME] = home_seen_q;
    stat_w[QEC_STAT_ARM] = next_arm_q;
    stat_w[QEC_STAT_IDX] = pins_lvl[2];
  end

  // Read multiplexer, unmapped offsets read zero
  always_comb begin
    rdat_d = '0;
    if (hit_ctrl) begin
      rdat_d = ctrl_ext;
    end else if (hit_init) begin
      rdat_d = QEC_DW'(init_q);
    end else if (hit_gec) begin
      rdat_d = QEC_DW'(gec_q);
    end else if (hit_pos) begin
      rdat_d = QEC_DW'(pos_q);
    end else if (hit_stat) begin
      rdat_d = stat_w;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ack_q <= 1'b0;
      rdat_q <= '0;
    end else begin
      ack_q <= bus_req;
      if (bus_req && !wb_we_i) begin
        rdat_q <= rdat_d;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ctrl_q <= QEC_CTRL_RST;
      init_q <= '0;
      gec_q <= '0;
      pos_q <= '0;
    end else begin
      ctrl_q <= ctrl_d;
      init_q <= init_d;
      gec_q <= gec_d;
      pos_q <= pos_d;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      home_seen_q <= 1'b0;
      idx_cnt_q <= 1'b0;
      next_arm_q <= 1'b0;
    end else begin
      home_seen_q <= home_seen_d;
      idx_cnt_q <= idx_cnt_d;
      next_arm_q <= next_arm_d;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;
  assign position_o = pos_q;
  assign running_o = run;

  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  sequence s_quiet;
    !step_up && !step_dn;
  endsequence

  sequence s_home_armed_second;
    run && idx_ev && (pim == QEC_PIM_HOME_IDX2) && home_seen_q && idx_cnt_q;
  endsequence

  sequence s_first_of_two;
    run && home_first && !home_ev;
  endsequence

  AST_EN_COUNT: assert property ((run && step_up && pim == QEC_PIM_NONE) |=> pos_q == $past(pos_q) + 1'b1)
    else $error("enabled counter did not advance");
  AST_STOPPED: assert property ((!run && !$past(srst)) |=> pos_q == $past(pos_q))
    else $error("stopped counter changed");
  AST_BUS_ACK: assert property ((wb_cyc_i && wb_stb_i && !ack_q) |=> ack_q)
    else $error("bus access not acknowledged");
  AST_IDLE_HALT: assert property ((ctl_sidl && device_idle) |-> !run)
    else $error("interface ran in idle with stop set");
  AST_IDLE_RUN: assert property ((ctl_en && !ctl_sidl) |-> run)
    else $error("interface halted with idle stop clear");
  AST_RSVD_MODE: assert property ((run && pim == QEC_PIM_RSVD) ##0 s_quiet |=> pos_q == $past(pos_q))
    else $error("reserved mode altered the counter");
  AST_MOD_WRAP: assert property ((run && is_mod && step_up && at_gec) |=> at_zero)
    else $error("modulo wrap up failed");
  AST_GEC_RST: assert property ((run && pim == QEC_PIM_GEC_RST && at_gec) |=> at_zero)
    else $error("counter not cleared at compare match");
  AST_SECOND_IDX: assert property (s_home_armed_second |=> pos_q == $past(init_q))
    else $error("second index after home did not load");
  AST_FIRST_IDX: assert property ((run && ev_home1) |=> pos_q == $past(init_q))
    else $error("first index after home did not load");
  AST_NEXT_IDX: assert property ((run && ev_next && !arm_on_write) |=> pos_q == $past(init_q) ##0 !next_arm_q)
    else $error("next index did not load once");
  AST_IDX_RST: assert property ((run && ev_idx_rst) |=> at_zero)
    else $error("index did not clear the counter");
  AST_IDX_NONE: assert property ((run && idx_ev && pim == QEC_PIM_NONE) ##0 s_quiet |=> pos_q == $past(pos_q))
    else $error("index changed the counter in mode none");
  AST_RSVD_BITS: assert property (ctrl_q[QEC_BIT_RSV_HI] == 1'b0 && ctrl_q[QEC_BIT_RSV_LO] == 1'b0)
    else $error("unimplemented control bit set");
  AST_RESET_CLR: assert property ($past(srst) |-> ctrl_q == QEC_CTRL_RST && !run)
    else $error("control not cleared by reset");

  // Bus side
  AST_ACK_PULSE: assert property (ack_q |=> !ack_q)
    else $error("acknowledge held longer than one cycle");
  AST_ACK_ONLY_REQ: assert property (ack_q |-> $past(wb_cyc_i) && $past(wb_stb_i))
    else $error("acknowledge without a request");
  AST_RSVD_RDATA: assert property ((ack_q && !$past(wb_we_i) && $past(hit_ctrl))
    |-> wb_dat_o[QEC_BIT_RSV_HI] == 1'b0 && wb_dat_o[QEC_BIT_RSV_LO] == 1'b0)
    else $error("unimplemented control bit read as one");

  // Run control
  AST_RUN_EN: assert property (!ctl_en |-> !run)
    else $error("counters ran with enable clear");
  AST_STOP_FLAGS: assert property (!run |=> home_seen_q == $past(home_seen_q) && idx_cnt_q == $past(idx_cnt_q))
    else $error("index tracking moved while stopped");

  // Position modes and index tracking
  AST_MOD_WRAP_DN: assert property ((run && is_mod && step_dn && at_zero) |=> pos_q == $past(gec_q))
    else $error("modulo wrap down failed");
  AST_HOME_ARM: assert property ((run && home_ev) |=> home_seen_q)
    else $error("home edge did not arm");
  AST_IDX_NO_HOME: assert property ((run && idx_ev && pim == QEC_PIM_HOME_IDX1 && !home_seen_q) ##0 s_quiet
    |=> pos_q == $past(pos_q))
    else $error("index before home changed the counter");
  AST_HOME1_CLR: assert property ((run && ev_home1 && !home_ev) |=> !home_seen_q)
    else $error("home flag kept after first index load");
  AST_FIRST_OF_TWO: assert property (s_first_of_two |=> idx_cnt_q && home_seen_q)
    else $error("first index after home not counted");
  AST_HOME2_CLR: assert property ((run && ev_home2 && !home_ev) |=> !idx_cnt_q && !home_seen_q)
    else $error("home tracking kept after second index load");
  AST_NEXT_DISARMED: assert property ((run && idx_ev && pim == QEC_PIM_IDX_NEXT && !next_arm_q) ##0 s_quiet
    |=> pos_q == $past(pos_q))
    else $error("disarmed next index changed the counter");
endmodule // qec_top
`default_nettype wire

// ### sim/qec_enc_model.sv
// Encoder model: drives phase A, phase B, index and home pins of the control block.
// Assumes the bench calls its tasks and sys_clk runs all the time.
`timescale 1ns/1ps
`default_nettype none
module qec_enc_model (
  input wire logic sys_clk,
  output logic pa,
  output logic pb,
  output logic idx,
  output logic home
);
  logic [1:0] s;
  initial begin
    s = 2'h0;
    pa = 1'b0;
    pb = 1'b0;
    idx = 1'b0;
    home = 1'b0;
  end
  // Hold each level well past the synchroniser and counter latency
  task automatic hold();
    repeat (12) @(posedge sys_clk);
  endtask
  // One x4 step, A leads B going up
  task automatic step(input logic up);
    @(posedge sys_clk);
    s = up ? s + 2'h1 : s - 2'h1;
    pa <= (s == 2'h1) || (s == 2'h2);
    pb <= s[1];
    hold();
  endtask
  task automatic step4();
    repeat (4) step(1'b1);
  endtask
  // Pulse the index pin (sel 0) or the home pin (sel 1)
  task automatic pulse(input logic sel);
    @(posedge sys_clk);
    if (sel) home <= 1'b1;
    else idx <= 1'b1;
    hold();
    home <= 1'b0;
    idx <= 1'b0;
    hold();
  endtask
endmodule // qec_enc_model
`default_nettype wire

// ### sim/tb.sv
// Testbench for the encoder control block: Wishbone register tests and pin-driven counter tests.
// Assumes qec_pkg, qec_top and the encoder model are compiled before it.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import qec_pkg::*;
  logic sys_clk;
  logic srst;
  logic cyc;
  logic stb;
  logic we;
  logic device_idle;
  logic [7:0] adr;
  logic [31:0] dat;
  logic [31:0] rd;
  logic [3:0] sel;
  logic [31:0] dat_o;
  logic [31:0] pos;
  logic ack;
  logic run;
  logic pa;
  logic pb;
  logic idx;
  logic home;
  int failures;
  int cmp_count;

  qec_top u_qec_top (
    .sys_clk(sys_clk),
    .srst(srst),
    .wb_cyc_i(cyc),
    .wb_stb_i(stb),
    .wb_we_i(we),
    .wb_adr_i(adr),
    .wb_dat_i(dat),
    .wb_sel_i(sel),
    .wb_dat_o(dat_o),
    .wb_ack_o(ack),
    .phase_a_input(pa),
    .phase_b_input(pb),
    .index_input(idx),
    .home_input(home),
    .device_idle(device_idle),
    .position_o(pos),
    .running_o(run)
  );

  qec_enc_model u_qec_enc_model (
    .sys_clk(sys_clk),
    .pa(pa),
    .pb(pb),
    .idx(idx),
    .home(home)
  );

  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  task automatic test_done();
    $display("failures=%0d compares=%0d", failures, cmp_count);
    if (failures == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask

  // Classic single Wishbone cycle, held until ack is sampled high
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    @(posedge sys_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    sel <= s;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (ack !== 1'b1) begin
      failures++;
      test_done();
    end
    rd = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  // Full-word write; one more edge so the new control value is visible to direct checks
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, 4'hF);
    @(posedge sys_clk);
  endtask

  task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0, 4'hF);
    chk(n, e, rd);
  endtask

  // Control word with index match levels taken from the present pin state
  function automatic logic [31:0] ctl(input logic en, input logic sidl, input logic [2:0] m);
    return {16'h0, en, 1'b0, sidl, m, u_qec_enc_model.pb, u_qec_enc_model.pa, 8'h00};
  endfunction

  initial begin
    failures = 0;
    cmp_count = 0;
    srst = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    dat = 32'h0;
    sel = 4'h0;
    device_idle = 1'b0;
    repeat (6) @(posedge sys_clk);
    srst <= 1'b0;
    rdc("ctrl reset", QEC_OFS_CTRL, 32'h0);
    chk("position reset", 32'h0, pos);
    chk("running reset", 32'h0, {31'h0, run});
    wr(QEC_OFS_CTRL, 32'h0000E3FF);
    rdc("ctrl rsv", QEC_OFS_CTRL, 32'h0000A37F);
    wr(QEC_OFS_CTRL, 32'h0);
    xfer(1'b1, QEC_OFS_CTRL, 32'h0000FFFF, 4'h1);
    rdc("ctrl lane0", QEC_OFS_CTRL, 32'h0000007F);
    rdc("unmapped", 8'h14, 32'h0);
    wr(QEC_OFS_POS, 32'h55);
    rdc("pos ro", QEC_OFS_POS, 32'h0);
    wr(QEC_OFS_INIT, 32'h1234);
    wr(QEC_OFS_GEC, 32'h10);
    rdc("gec", QEC_OFS_GEC, 32'h10);
    u_qec_enc_model.step(1'b1);
    chk("pos off", 32'h0, pos);
    rdc("init off", QEC_OFS_INIT, 32'h1234);
    wr(QEC_OFS_CTRL, ctl(1'b1, 1'b0, 3'h0));
    chk("running on", 32'h1, {31'h0, run});
    rdc("stat run", QEC_OFS_STAT, 32'h1);
    u_qec_enc_model.step4();
    chk("pos count", 32'h4, pos);
    rdc("pos reg", QEC_OFS_POS, 32'h4);
    u_qec_enc_model.pulse(1'b0);
    chk("mode0 idx", 32'h4, pos);
    wr(QEC_OFS_CTRL, ctl(1'b1, 1'b0, 3'h1) ^ 32'h100);
    u_qec_enc_model.pulse(1'b0);
    chk("a mismatch", 32'h4, pos);
    wr(QEC_OFS_CTRL, ctl(1'b1, 1'b0, 3'h1) ^ 32'h200);
    u_qec_enc_model.pulse(1'b0);
    chk("b mismatch", 32'h4, pos);
    wr(QEC_OFS_CTRL, ctl(1'b1, 1'b0, 3'h1));
    u_qec_enc_model.pulse(1'b0);
    chk("mode1 idx", 32'h0, pos);
    wr(QEC_OFS_CTRL, ctl(1'b1, 1'b0, 3'h2));
    u_qec_enc_model.pulse(1'b0);
    chk("mode2 load", 32'h1234, pos);
    u_qec_enc_model.step4();
    u_qec_enc_model.pulse(1'b0);
    chk("mode2 once", 32'h1238, pos);
    wr(QEC_OFS_CTRL, ctl(1'b1, 1'b0, 3'h3));
    u_qec_enc_model.pulse(1'b0);
    chk("mode3 nohome", 32'h1238, pos);
    u_qec_enc_model.pulse(1'b1);
    u_qec_enc_model.pulse(1'b0);
    chk("mode3 load", 32'h1234, pos);
    u_qec_enc_model.step4();
    wr(QEC_OFS_CTRL, ctl(1'b1, 1'b0, 3'h4));
    u_qec_enc_model.pulse(1'b1);
    u_qec_enc_model.pulse(1'b0);
    chk("mode4 first", 32'h1238, pos);
    u_qec_enc_model.pulse(1'b0);
    chk("mode4 second", 32'h1234, pos);
    wr(QEC_OFS_GEC, 32'h1236);
    wr(QEC_OFS_CTRL, ctl(1'b1, 1'b0, 3'h5));
    u_qec_enc_model.step(1'b1);
    chk("mode5 below", 32'h1235, pos);
    u_qec_enc_model.step(1'b1);
    chk("mode5 clear", 32'h0, pos);
    wr(QEC_OFS_GEC, 32'h3);
    wr(QEC_OFS_CTRL, ctl(1'b1, 1'b0, 3'h6));
    u_qec_enc_model.step(1'b0);
    chk("mod wrap dn", 32'h3, pos);
    u_qec_enc_model.step(1'b1);
    chk("mod wrap up", 32'h0, pos);
    @(posedge sys_clk);
    device_idle <= 1'b1;
    wr(QEC_OFS_CTRL, ctl(1'b1, 1'b1, 3'h0));
    chk("idle stop run", 32'h0, {31'h0, run});
    u_qec_enc_model.step(1'b1);
    chk("idle stop pos", 32'h0, pos);
    wr(QEC_OFS_CTRL, ctl(1'b1, 1'b0, 3'h0));
    chk("idle run", 32'h1, {31'h0, run});
    u_qec_enc_model.step(1'b1);
    chk("idle pos", 32'h1, pos);
    test_done();
  end
endmodule // tb
`default_nettype wire
